//--- design/pam_pkg.sv
// Purpose: shared constants and types for the upper port pin muxing block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes:   analog select bit set means the pin is digital
package pam_pkg;
    // ========================================
    // widths
    localparam int PAM_W      = 8;
    localparam int PAM_ADR_W  = 8;
    localparam int PAM_DAT_W  = 32;
    // lowest address bit that selects a register word
    localparam int PAM_WORD_LSB = 2;

    // ========================================
    // register byte offsets
    localparam logic [PAM_ADR_W-1:0] PAM_OFS_PORT = 8'h00;
    localparam logic [PAM_ADR_W-1:0] PAM_OFS_LAT  = 8'h04;
    localparam logic [PAM_ADR_W-1:0] PAM_OFS_DIR  = 8'h08;
    localparam logic [PAM_ADR_W-1:0] PAM_OFS_ANA  = 8'h0C;
    localparam logic [PAM_ADR_W-1:0] PAM_OFS_CTRL = 8'h10;

    // ========================================
    // masks and reset values
    localparam logic [PAM_W-1:0] PAM_IMPL_MASK  = 8'hEF;
    localparam logic [PAM_W-1:0] PAM_ANA_MASK   = 8'h2C;
    localparam logic [PAM_W-1:0] PAM_CTRL_MASK  = 8'h0F;
    localparam logic [PAM_W-1:0] PAM_LAT_RST    = 8'h00;
    localparam logic [PAM_W-1:0] PAM_DIR_RST    = 8'hEF;
    localparam logic [PAM_W-1:0] PAM_ANA_RST    = 8'h00;
    localparam logic [PAM_W-1:0] PAM_CTRL_RST   = 8'h00;

    // ========================================
    // pin and field positions
    localparam int PAM_B2  = 2;
    localparam int PAM_B3  = 3;
    localparam int PAM_B4  = 4;
    localparam int PAM_B5  = 5;
    localparam int PAM_B6  = 6;
    localparam int PAM_B7  = 7;
    localparam int PAM_CTRL_REFOUT = 0;
    localparam int PAM_CTRL_AFUNC2 = 1;
    localparam int PAM_CTRL_OSC_LO = 2;
    localparam int PAM_CTRL_OSC_HI = 3;

    // ========================================
    // cycle clock: oscillator divided by four
    localparam int PAM_CYC_DIV = 4;
    localparam int PAM_CNT_W   = 2;

    typedef enum logic [1:0] {
        PAM_OSC_HS     = 2'b00,
        PAM_OSC_EXTCLK = 2'b01,
        PAM_OSC_RESCAP = 2'b10,
        PAM_OSC_INT    = 2'b11
    } pam_osc_e;
endpackage : pam_pkg

//--- design/pam_pin_if.sv
// Purpose: carries raw pin levels to the synchroniser and clean levels back
// Assumes: single clock domain on the clean side
// Notes:   none
`timescale 1ns/1ns
interface pam_pin_if;
    logic [7:0] pinRaw;
    logic [7:0] pinSync;
    modport syncer (input pinRaw, output pinSync);
    modport user   (output pinRaw, input pinSync);
endinterface : pam_pin_if

//--- design/pam_pin_sync.sv
// Purpose: two-stage synchroniser for the port pins
// Assumes: pins may change at any time
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module pam_pin_sync
    import pam_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   rstn,
    pam_pin_if.syncer   pins
);
    logic [PAM_W-1:0] meta_q;
    logic [PAM_W-1:0] sync_q;

    // ========================================
    // synchroniser
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_q <= 8'h00;
            sync_q <= 8'h00;
        end else begin
            meta_q <= pins.pinRaw;
            sync_q <= meta_q;
        end
    end

    assign pins.pinSync = sync_q;

    // ========================================
    // checks
    logic [1:0] age_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            age_q <= 2'h0;
        end else if (age_q != 2'h3) begin
            age_q <= age_q + 2'h1;
        end
    end

    a_sync_two_stage: assert property (@(posedge clock) disable iff (!rstn)
        (age_q == 2'h3) |-> (pins.pinSync == $past(pins.pinRaw, 2)))
        else $error("pin level not delayed by two stages");
endmodule : pam_pin_sync

//--- design/pam_cycle_div.sv
// Purpose: derives the cycle clock level, oscillator divided by four
// Assumes: run held for as long as the clock must appear
// Notes:   level is low while run is low
`timescale 1ns/1ns
module pam_cycle_div
    import pam_pkg::*;
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic run,
    output logic      cycleLevel
);
    logic [PAM_CNT_W-1:0] cnt_q;

    // ========================================
    // divider
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            cycleLevel <= 1'b0;
        end else begin
            cycleLevel <= run & cnt_q[PAM_CNT_W-1];
        end
    end
endmodule : pam_cycle_div

//--- design/pam_port_top.sv
// Purpose: upper pin muxing of a bidirectional general-purpose port
// Assumes: pins synchronous after two stages; classic Wishbone slave
// Notes:   pinOut and pinOe are registered, one cycle behind the registers
//
// Summary of operation
// - direction 1 is input, 0 drives latch
// - port read gives pins, write sets latch
// - analog select bits choose analog or digital
// - bit 2 driver off when reference out enabled
// - bit 2 read off for analog or reference
// - bit 3 read off while analog
// - bit 5 read off while analog
// - analog select never gates the output path
// - analog-capable pins analog after reset
// - resistor-capacitor and external-clock modes clock bit 6
// - don't-care pins ignore their direction bit
// - bit 5 feeds slave select when input
// - bit 5 is remap pin two, in or out
// - bit 4 unimplemented, reads zero
//
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
module pam_port_top
    import pam_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 rstn,
    input  wire logic                 cyc_i,
    input  wire logic                 stb_i,
    input  wire logic                 we_i,
    input  wire logic [PAM_ADR_W-1:0] adr_i,
    input  wire logic [3:0]           sel_i,
    input  wire logic [PAM_DAT_W-1:0] dat_i,
    output logic      [PAM_DAT_W-1:0] dat_o,
    output logic                      ack_o,
    input  wire logic [PAM_W-1:0]     pinIn,
    output logic      [PAM_W-1:0]     pinOut,
    output logic      [PAM_W-1:0]     pinOe,
    input  wire logic                 remapPin2Out,
    input  wire logic                 remapPin2OutEn,
    output logic                      remapPin2In,
    output logic                      serialSlaveSelectN
);
    // ========================================
    // storage
    logic [PAM_W-1:0] lat_q;
    logic [PAM_W-1:0] dir_q;
    logic [PAM_W-1:0] ana_q;
    logic [PAM_W-1:0] ctrl_q;
    logic [PAM_W-1:0] portRead;
    logic [PAM_W-1:0] readable;
    logic [PAM_W-1:0] oe_d;
    logic [PAM_W-1:0] out_d;
    logic [PAM_W-1:0] rdByte;
    logic             access;
    logic             wrLow;
    logic             refOutOn;
    logic             afunc2On;
    logic             cycleLevel;
    logic             cycleRun;
    pam_osc_e         oscMode;

    pam_pin_if pinBus ();

    assign pinBus.pinRaw = pinIn;

    pam_pin_sync u_sync (
        .clock (clock),
        .rstn  (rstn),
        .pins  (pinBus.syncer)
    );

    // ========================================
    // control decode
    assign refOutOn = ctrl_q[PAM_CTRL_REFOUT];
    assign afunc2On = ctrl_q[PAM_CTRL_AFUNC2];
    assign oscMode  = pam_osc_e'(ctrl_q[PAM_CTRL_OSC_HI:PAM_CTRL_OSC_LO]);
    assign cycleRun = (oscMode == PAM_OSC_RESCAP) || (oscMode == PAM_OSC_EXTCLK);

    pam_cycle_div u_div (
        .clock      (clock),
        .rstn       (rstn),
        .run        (cycleRun),
        .cycleLevel (cycleLevel)
    );

    // a set analog select bit means the pin is digital
    function automatic logic isDigital(input logic [PAM_W-1:0] ana, input int bitPos);
        isDigital = ana[bitPos];
    endfunction : isDigital

    function automatic logic [PAM_W-1:0] lowByte(input logic [PAM_DAT_W-1:0] d, input logic [PAM_W-1:0] mask);
        lowByte = d[PAM_W-1:0] & mask;
    endfunction : lowByte

    // word decode ignores the byte-lane address bits
    function automatic logic hitsWord(input logic [PAM_ADR_W-1:0] adr, input logic [PAM_ADR_W-1:0] ofs);
        hitsWord = (adr[PAM_ADR_W-1:PAM_WORD_LSB] == ofs[PAM_ADR_W-1:PAM_WORD_LSB]);
    endfunction : hitsWord

    // ========================================
    // input read gating
    always_comb begin
        // gating after the synchroniser keeps a floating analog pin out of the port read, but not out of the bit 5 peripheral inputs
        readable          = PAM_IMPL_MASK;
        readable[PAM_B2]  = isDigital(ana_q, PAM_B2) && !afunc2On && !refOutOn;
        readable[PAM_B3]  = isDigital(ana_q, PAM_B3);
        readable[PAM_B5]  = isDigital(ana_q, PAM_B5);
        // oscillator-owned pins have no digital input
        readable[PAM_B6]  = (oscMode == PAM_OSC_INT);
        readable[PAM_B7]  = (oscMode == PAM_OSC_INT);
        readable[PAM_B4]  = 1'b0;
    end

    assign portRead = pinBus.pinSync & readable;

    // ========================================
    // output drive
    always_comb begin
        oe_d  = ~dir_q & PAM_IMPL_MASK;
        out_d = lat_q & PAM_IMPL_MASK;
        // the reference output owns bit 2 whatever the direction bit says
        if (refOutOn) begin
            oe_d[PAM_B2] = 1'b0;
        end
        if (!dir_q[PAM_B5] && remapPin2OutEn) begin
            out_d[PAM_B5] = remapPin2Out;
        end
        case (oscMode)
            PAM_OSC_HS: begin
                oe_d[PAM_B6] = 1'b0;
                oe_d[PAM_B7] = 1'b0;
            end
            PAM_OSC_EXTCLK, PAM_OSC_RESCAP: begin
                oe_d[PAM_B6]  = 1'b1;
                out_d[PAM_B6] = cycleLevel;
                oe_d[PAM_B7]  = 1'b0;
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pinOe  <= 8'h00;
            pinOut <= 8'h00;
        end else begin
            // registering the drive costs a cycle but keeps decode glitches off the pins
            pinOe  <= oe_d;
            pinOut <= out_d;
        end
    end

    // ========================================
    // peripheral inputs on bit 5
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            serialSlaveSelectN <= 1'b1;
            remapPin2In        <= 1'b0;
        end else begin
            // output mode leaves the slave deselected
            serialSlaveSelectN <= dir_q[PAM_B5] ? pinBus.pinSync[PAM_B5] : 1'b1;
            remapPin2In        <= dir_q[PAM_B5] & pinBus.pinSync[PAM_B5];
        end
    end

    // ========================================
    // wishbone slave
    // ack drops every other cycle, so a request held past ack is served twice
    assign access = cyc_i && stb_i && !ack_o;
    assign wrLow  = access && we_i && sel_i[0];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            lat_q <= PAM_LAT_RST;
        end else if (wrLow && (hitsWord(adr_i, PAM_OFS_PORT) || hitsWord(adr_i, PAM_OFS_LAT))) begin
            lat_q <= lowByte(dat_i, PAM_IMPL_MASK);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dir_q <= PAM_DIR_RST;
        end else if (wrLow && hitsWord(adr_i, PAM_OFS_DIR)) begin
            dir_q <= lowByte(dat_i, PAM_IMPL_MASK);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ana_q <= PAM_ANA_RST;
        end else if (wrLow && hitsWord(adr_i, PAM_OFS_ANA)) begin
            ana_q <= lowByte(dat_i, PAM_ANA_MASK);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= PAM_CTRL_RST;
        end else if (wrLow && hitsWord(adr_i, PAM_OFS_CTRL)) begin
            ctrl_q <= lowByte(dat_i, PAM_CTRL_MASK);
        end
    end

    // unmapped words answer with zero so the master never hangs
    always_comb begin
        if (hitsWord(adr_i, PAM_OFS_PORT)) begin
            rdByte = portRead;
        end else if (hitsWord(adr_i, PAM_OFS_LAT)) begin
            rdByte = lat_q;
        end else if (hitsWord(adr_i, PAM_OFS_DIR)) begin
            rdByte = dir_q;
        end else if (hitsWord(adr_i, PAM_OFS_ANA)) begin
            rdByte = ana_q;
        end else if (hitsWord(adr_i, PAM_OFS_CTRL)) begin
            rdByte = ctrl_q;
        end else begin
            rdByte = 8'h00;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= access;
            if (access && !we_i) begin
                dat_o <= {24'h00_0000, rdByte};
            end
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    // pin levels are compared against the synchronised copy, two clocks behind the pads
    logic             portRdGo;
    logic             latRdGo;
    logic [PAM_W-1:0] wrByte;
    assign portRdGo = access && !we_i && hitsWord(adr_i, PAM_OFS_PORT);
    assign latRdGo  = access && !we_i && hitsWord(adr_i, PAM_OFS_LAT);
    assign wrByte   = lowByte(dat_i, PAM_IMPL_MASK);

    a_input_hiz_dir: assert property (dir_q[PAM_B3] |=> !pinOe[PAM_B3])
        else $error("input pin still driven");

    a_port_read_pins: assert property (
        portRdGo && readable[PAM_B3] |=> ack_o && dat_o[PAM_B3] == $past(pinBus.pinSync[PAM_B3]))
        else $error("port read does not show pin level");

    a_refout_driver_off: assert property (refOutOn |=> !pinOe[PAM_B2])
        else $error("bit 2 driven with reference output on");

    a_bit2_read_gate: assert property (
        portRdGo && (!ana_q[PAM_B2] || afunc2On || refOutOn) |=> !dat_o[PAM_B2])
        else $error("bit 2 read while analog");

    a_bit3_read_gate: assert property (portRdGo && !ana_q[PAM_B3] |=> !dat_o[PAM_B3])
        else $error("bit 3 read while analog");

    a_bit5_read_gate: assert property (portRdGo && !ana_q[PAM_B5] |=> !dat_o[PAM_B5])
        else $error("bit 5 read while analog");

    a_output_not_gated: assert property (
        !dir_q[PAM_B3] && !ana_q[PAM_B3] |=> pinOe[PAM_B3] && pinOut[PAM_B3] == $past(lat_q[PAM_B3]))
        else $error("analog select gated the output");

    a_analog_after_reset: assert property (!$past(rstn) |-> (ana_q & PAM_ANA_MASK) == 8'h00)
        else $error("analog pins not analog after reset");

    a_cycle_clock_rate: assert property (
        $rose(cycleLevel) ##1 cycleRun[*2] |-> $fell(cycleLevel))
        else $error("cycle clock not a quarter of the clock");

    a_cycle_clock_pin: assert property (
        cycleRun ##1 cycleRun |-> pinOe[PAM_B6] && pinOut[PAM_B6] == $past(cycleLevel))
        else $error("cycle clock missing on bit 6");

    a_osc_dir_ignored: assert property ((oscMode == PAM_OSC_HS) |=> !pinOe[PAM_B6] && !pinOe[PAM_B7])
        else $error("oscillator pin driven");

    a_slave_select_in: assert property (!dir_q[PAM_B5] |=> serialSlaveSelectN)
        else $error("slave select active with output direction");

    a_remap_out_drive: assert property (
        !dir_q[PAM_B5] && remapPin2OutEn |=> pinOut[PAM_B5] == $past(remapPin2Out))
        else $error("remap output not on bit 5");

    a_bit4_reads_zero: assert property (ack_o |-> !dat_o[PAM_B4] && !pinOe[PAM_B4])
        else $error("bit 4 not zero");

    a_bit2_read_pins: assert property (
        portRdGo && ana_q[PAM_B2] && !afunc2On && !refOutOn |=> dat_o[PAM_B2] == $past(pinBus.pinSync[PAM_B2]))
        else $error("bit 2 digital read lost the pin level");

    a_bit5_read_pins: assert property (
        portRdGo && ana_q[PAM_B5] |=> dat_o[PAM_B5] == $past(pinBus.pinSync[PAM_B5]))
        else $error("bit 5 digital read lost the pin level");

    a_osc_read_zero: assert property (
        portRdGo && (oscMode != PAM_OSC_INT) |=> !dat_o[PAM_B6] && !dat_o[PAM_B7])
        else $error("oscillator pin read as digital");

    a_clock_bit7_idle: assert property (cycleRun |=> !pinOe[PAM_B7])
        else $error("bit 7 driven while the cycle clock runs");

    a_port_write_latch: assert property (wrLow && hitsWord(adr_i, PAM_OFS_PORT) |=> lat_q == $past(wrByte))
        else $error("port write did not reach the latch");

    a_latch_read_back: assert property (latRdGo |=> dat_o[PAM_W-1:0] == $past(lat_q))
        else $error("latch read does not show the latch");

    a_bit4_stays_zero: assert property (!dir_q[PAM_B4] && !lat_q[PAM_B4])
        else $error("bit 4 of direction or latch set");

    a_ack_one_cycle: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");

    a_remap_in_follow: assert property (
        dir_q[PAM_B5] |=> remapPin2In == $past(pinBus.pinSync[PAM_B5]))
        else $error("remap input does not follow bit 5");

    a_slave_select_pin: assert property (
        dir_q[PAM_B5] |=> serialSlaveSelectN == $past(pinBus.pinSync[PAM_B5]))
        else $error("slave select does not follow bit 5");

    a_analog_drive_bit5: assert property (
        !dir_q[PAM_B5] && !ana_q[PAM_B5] && !remapPin2OutEn |=> pinOe[PAM_B5] && pinOut[PAM_B5] == $past(lat_q[PAM_B5]))
        else $error("analog select gated the bit 5 output");

    c_port_read:   cover property (portRdGo ##1 ack_o);
    c_latch_read:  cover property (latRdGo ##1 ack_o);
    c_cycle_clock: cover property (cycleRun ##1 $rose(cycleLevel));
    c_remap_out:   cover property (!dir_q[PAM_B5] && remapPin2OutEn ##1 pinOe[PAM_B5]);
    c_refout_on:   cover property (refOutOn && !dir_q[PAM_B2]);
endmodule : pam_port_top

//--- bench/tb_top.sv
// Purpose: self-checking bench for the upper port pin muxing block
// Assumes: classic Wishbone single cycles, ack one cycle after the request is taken
// Notes:   assertions live in the design files; this bench drives every port itself
`timescale 1ns/1ns
module tb_top;
    import pam_pkg::*;
    logic                 clock;
    logic                 rstn;
    logic                 cyc;
    logic                 stb;
    logic                 we;
    logic [PAM_ADR_W-1:0] adr;
    logic [3:0]           sel;
    logic [PAM_DAT_W-1:0] datW;
    logic [PAM_DAT_W-1:0] datR;
    logic                 ack;
    logic [PAM_W-1:0]     pinIn;
    logic [PAM_W-1:0]     pinOut;
    logic [PAM_W-1:0]     pinOe;
    logic                 rpOut;
    logic                 rpOutEn;
    logic                 rpIn;
    logic                 ssN;
    int                   errors;
    int                   checked;
    int                   cycles;
    int                   highs;
    int                   flips;
    logic                 prev;
    logic [PAM_W-1:0]     rv;

    pam_port_top i_dut (
        .clock(clock), .rstn(rstn), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .remapPin2Out(rpOut), .remapPin2OutEn(rpOutEn),
        .remapPin2In(rpIn), .serialSlaveSelectN(ssN)
    );

    // ========================================
    // clock and timeout
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    // a hang shows up as a missing ack; 5000 cycles is far beyond the test length
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors = errors + 1;
            $display("wrong value timeout expected done seen hang");
            complete_run();
        end
    end

    // ========================================
    // bus tasks
    task automatic wbAccess(input logic w, input logic [7:0] a, input logic [7:0] d,
                            input logic [3:0] s, output logic [7:0] q);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        sel  <= s;
        datW <= {24'h000000, d};
        do @(posedge clock); while (ack !== 1'b1);
        q = datR[7:0];
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge clock);
    endtask : wbAccess

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        wbAccess(1'b1, a, d, 4'hF, q);
    endtask : wr

    task automatic checkVal(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked = checked + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : checkVal

    task automatic rdChk(input string name, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] q;
        wbAccess(1'b0, a, 8'h00, 4'hF, q);
        checkVal(name, exp, q);
    endtask : rdChk

    task automatic waitClk(input int n);
        repeat (n) @(posedge clock);
    endtask : waitClk

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : complete_run

    // ========================================
    // main sequence
    initial begin
        errors = 0; checked = 0; cycles = 0;
        rstn = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; sel = 4'h0;
        datW = 32'h00000000; pinIn = 8'hFF; rpOut = 1'b0; rpOutEn = 1'b0;
        waitClk(3);
        rstn <= 1'b1;
        waitClk(3);
        // reset values and power-on analog defaults
        rdChk("lat reset", PAM_OFS_LAT, 8'h00);
        rdChk("dir reset", PAM_OFS_DIR, 8'hEF);
        rdChk("ana reset", PAM_OFS_ANA, 8'h00);
        rdChk("ctrl reset", PAM_OFS_CTRL, 8'h00);
        rdChk("port after reset", PAM_OFS_PORT, 8'h03);
        checkVal("oe after reset", 8'h00, pinOe);
        $display("test reset done");
        // digital reads once analog select is set, internal oscillator mode
        wr(PAM_OFS_ANA, 8'hFF);
        rdChk("ana mask", PAM_OFS_ANA, 8'h2C);
        wr(PAM_OFS_CTRL, 8'h0C);
        rdChk("port digital", PAM_OFS_PORT, 8'hEF);
        wr(PAM_OFS_ANA, 8'h24);
        rdChk("bit3 analog", PAM_OFS_PORT, 8'hE7);
        wr(PAM_OFS_ANA, 8'h0C);
        rdChk("bit5 analog", PAM_OFS_PORT, 8'hCF);
        wr(PAM_OFS_ANA, 8'h28);
        rdChk("bit2 analog", PAM_OFS_PORT, 8'hEB);
        wr(PAM_OFS_ANA, 8'h2C);
        wr(PAM_OFS_CTRL, 8'h0E);
        rdChk("bit2 afunc", PAM_OFS_PORT, 8'hEB);
        wr(PAM_OFS_CTRL, 8'h0D);
        rdChk("bit2 refout", PAM_OFS_PORT, 8'hEB);
        $display("test read gating done");
        // synchroniser: a change together with a read is not yet seen
        wr(PAM_OFS_CTRL, 8'h0C);
        pinIn <= 8'h00;
        rdChk("sync old", PAM_OFS_PORT, 8'hEF);
        rdChk("sync new", PAM_OFS_PORT, 8'h00);
        $display("test synchroniser done");
        // output path: analog select does not gate the drive
        wr(PAM_OFS_ANA, 8'h00);
        wr(PAM_OFS_DIR, 8'h00);
        wr(PAM_OFS_PORT, 8'hFF);
        rdChk("lat via port", PAM_OFS_LAT, 8'hEF);
        rdChk("dir bit4", PAM_OFS_DIR, 8'h00);
        waitClk(2);
        checkVal("oe all out", 8'hEF, pinOe);
        checkVal("drive value", 8'hEF, pinOut & pinOe);
        wr(PAM_OFS_LAT, 8'h00);
        waitClk(2);
        checkVal("drive zero", 8'h00, pinOut & pinOe);
        wr(PAM_OFS_CTRL, 8'h0D);
        waitClk(2);
        checkVal("refout oe", 8'hEB, pinOe);
        wr(PAM_OFS_DIR, 8'hEF);
        waitClk(2);
        checkVal("oe inputs", 8'h00, pinOe);
        $display("test drive done");
        // oscillator modes: cycle clock on bit 6 whatever the direction bit
        for (int m = 0; m < 3; m++) begin
            wr(PAM_OFS_DIR, (m == 0) ? 8'h00 : 8'hEF);
            wr(PAM_OFS_CTRL, {4'h0, m[1:0], 2'b00});
            waitClk(4);
            checkVal("osc oe6", (m == 0) ? 8'h00 : 8'h01, {7'h00, pinOe[6]});
            checkVal("osc oe7", 8'h00, {7'h00, pinOe[7]});
            if (m != 0) begin
                highs = 0;
                flips = 0;
                @(posedge clock);
                prev = pinOut[6];
                for (int k = 0; k < 8; k++) begin
                    @(posedge clock);
                    highs = highs + ((pinOut[6] === 1'b1) ? 1 : 0);
                    flips = flips + ((pinOut[6] !== prev) ? 1 : 0);
                    prev = pinOut[6];
                end
                checkVal("cycle highs", 8'h04, highs[7:0]);
                checkVal("cycle edges", 8'h04, flips[7:0]);
            end
        end
        $display("test oscillator done");
        // bit 5 peripheral routing
        wr(PAM_OFS_CTRL, 8'h0C);
        wr(PAM_OFS_ANA, 8'h2C);
        pinIn <= 8'h00;
        waitClk(4);
        checkVal("ss low", 8'h00, {7'h00, ssN});
        checkVal("remap in low", 8'h00, {7'h00, rpIn});
        pinIn <= 8'h20;
        waitClk(4);
        checkVal("ss high", 8'h01, {7'h00, ssN});
        checkVal("remap in high", 8'h01, {7'h00, rpIn});
        wr(PAM_OFS_DIR, 8'hCF);
        rpOut   <= 1'b1;
        rpOutEn <= 1'b1;
        waitClk(3);
        checkVal("remap in off", 8'h00, {7'h00, rpIn});
        checkVal("ss off", 8'h01, {7'h00, ssN});
        checkVal("remap out", 8'h30, {2'b00, pinOut[5], pinOe[5], 4'h0});
        rpOutEn <= 1'b0;
        waitClk(3);
        checkVal("latch out", 8'h10, {2'b00, pinOut[5], pinOe[5], 4'h0});
        $display("test bit5 routing done");
        // unmapped address and masked byte lane
        wr(8'h20, 8'h55);
        rdChk("unmapped", 8'h20, 8'h00);
        wbAccess(1'b1, PAM_OFS_LAT, 8'h55, 4'hE, rv);
        rdChk("sel dropped", PAM_OFS_LAT, 8'h00);
        $display("test bus corners done");
        complete_run();
    end
endmodule : tb_top
